// *** src/progress_format_defs.vh ***
// Constants for the progress marker and format command block
`ifndef PROGRESS_FORMAT_DEFS_VH
`define PROGRESS_FORMAT_DEFS_VH

// Register byte addresses
`define REG_CMD_CTRL 5'h00
`define REG_CMD_DW10 5'h04
`define REG_CMD_DW11 5'h08
`define REG_CMD_NSID 5'h0c
`define REG_CPL_DW0 5'h10
`define REG_STATUS 5'h14
`define REG_IRQ_STAT 5'h18
`define REG_IRQ_MASK 5'h1c
`define ADDR_W 5

// Command control register: opcode in low byte, feature id in next byte
`define OPC_SET_FEAT 8'h09
`define OPC_GET_FEAT 8'h0a
`define OPC_FORMAT 8'h80
`define FID_PROGRESS 8'h80

// Command dword fields
`define LOAD_COUNT_HI 7
`define GO_BIT 16
`define OPC_HI 7
`define OPC_LO 0
`define FID_HI 15
`define FID_LO 8
`define FMT_SET_HI 11
`define ERASE_SEL_HI 11
`define ERASE_SEL_LO 9
`define ERASE_NONE 3'h0
`define ERASE_USER 3'h1
`define ERASE_CRYPTO 3'h2
`define NSID_ALL 32'hffffffff

// Completion status codes
`define ST_OK 8'h00
`define ST_INVALID_OPC 8'h01
`define ST_INVALID_FIELD 8'h02
`define ST_INVALID_NS 8'h0b
`define ST_SEC_STATE 8'h20

// Interrupt status bits
`define IRQ_SET_DONE 0
`define IRQ_GET_DONE 1
`define IRQ_FMT_DONE 2
`define IRQ_CMD_ERR 3
`define IRQ_W 4

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** src/progress_format_cmd.v ***
// Admin command front end: progress marker feature and format command
//
// Notes on behaviour
// - Optional feature 80h holds a progress marker via set and get feature.
// - Stored marker survives power state changes; later get returns last set.
// - Get feature for the marker returns attributes in completion dword 0.
// - Marker comes from command dword 11 bits 7:0; bits 31:8 reserved.
// - After applying set feature attributes, a completion is posted.
// - Format command triggers a low level format, per-namespace or all.
// - Host may request user data erase or cryptographic erase with format.
// - Format fails when the controller is in an invalid security state.
// - Applied format settings are reported in namespace identify data.
// - Namespace FFFFFFFFh formats all namespaces regardless of attributes; refused with invalid namespace when multi_ns_supported_i is low.
// - Format uses only dword 10; bits 31:12 reserved.
// - Secure erase field selects erase type; erase covers all user data.
// - Erase field bits 11:9: 0 none, 1 user, 2 crypto, rest reserved.
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "progress_format_defs.vh"

module progress_format_cmd (
	input wire clk_i,
	input wire rst_n_i,
	input wire [`ADDR_W-1:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`ADDR_W-1:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire security_state_invalid_i,
	input wire multi_ns_supported_i,
	input wire format_busy_i,
	output wire format_start_o,
	output wire format_all_ns_o,
	output wire [31:0] format_nsid_o,
	output wire [11:0] format_settings_o,
	output wire [2:0] secure_erase_select_o,
	output wire [11:0] ns_reported_settings_o,
	output wire [7:0] preboot_load_count_o,
	output wire irq_o
);

	localparam ST_IDLE = 3'b001;
	localparam ST_FMT = 3'b010;
	localparam ST_WAIT = 3'b100;

	// Write channel: address and data latched independently
	reg aw_held;
	reg [`ADDR_W-1:0] aw_addr;
	reg w_held;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	reg bvalid;
	reg [1:0] bresp;
	reg arready;
	reg rvalid;
	reg [31:0] rdata;
	reg [1:0] rresp;

	// Command staging and results
	reg [15:0] cmd_ctrl;
	reg [31:0] cmd_dw10;
	reg [31:0] cmd_dw11;
	reg [31:0] cmd_nsid;
	reg [31:0] cpl_dw0;
	reg [7:0] cpl_status;
	reg [7:0] preboot_load_count;
	reg [`IRQ_W-1:0] irq_stat;
	reg [`IRQ_W-1:0] irq_mask;
	reg irq;
	reg [2:0] state;
	reg fmt_start;
	reg fmt_all;
	reg [31:0] fmt_nsid;
	reg [11:0] fmt_settings;
	reg [11:0] ns_settings;

	wire wr_fire = aw_held && w_held && !bvalid;
	wire go = wr_fire && aw_addr == `REG_CMD_CTRL && w_strb[0] && w_data[`GO_BIT];
	wire [7:0] go_opc = w_data[`OPC_HI:`OPC_LO];
	wire [7:0] go_fid = w_data[`FID_HI:`FID_LO];
	wire [2:0] erase_sel = cmd_dw10[`ERASE_SEL_HI:`ERASE_SEL_LO];
	// Reserved erase codes are refused up front rather than passed to the engine
	wire erase_ok = erase_sel == `ERASE_NONE || erase_sel == `ERASE_USER || erase_sel == `ERASE_CRYPTO;
	wire ns_all = cmd_nsid == `NSID_ALL;

	// Control word merged with its byte strobes; only the low half is stored
	wire [31:0] ctrl_merged = merge({16'h0000, cmd_ctrl}, w_data, w_strb);

	// Status word: code in the low byte, busy above it, last reported settings OR'd in
	wire busy_flag = state != ST_IDLE;
	wire [31:0] status_word = {20'h00000, ns_settings} | {15'h0000, busy_flag, 8'h00, cpl_status};

	// Apart from reset, a set of the marker feature is the only thing that writes the stored count
	wire marker_set = state == ST_IDLE && go && go_opc == `OPC_SET_FEAT && go_fid == `FID_PROGRESS;

	assign s_axi_awready = !aw_held;
	assign s_axi_wready = !w_held;
	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_arready = arready;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rdata = rdata;
	assign s_axi_rresp = rresp;
	assign format_start_o = fmt_start;
	assign format_all_ns_o = fmt_all;
	assign format_nsid_o = fmt_nsid;
	assign format_settings_o = fmt_settings;
	assign secure_erase_select_o = fmt_settings[`ERASE_SEL_HI:`ERASE_SEL_LO];
	assign ns_reported_settings_o = ns_settings;
	assign preboot_load_count_o = preboot_load_count;
	assign irq_o = irq;

	// Byte lane merge for writes into staging registers
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nv;
		input [3:0] be;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (be[i])
					merge[i*8 +: 8] = nv[i*8 +: 8];
			end
		end
	endfunction

	reg [`IRQ_W-1:0] irq_set;
	reg [`IRQ_W-1:0] next_irq_stat;
	always @* begin
		next_irq_stat = irq_stat;
		if (wr_fire && aw_addr == `REG_IRQ_STAT && w_strb[0])
			next_irq_stat = irq_stat & ~w_data[`IRQ_W-1:0];
		// Set wins over a clear in the same cycle
		next_irq_stat = next_irq_stat | irq_set;
	end

	// Format checks in priority order: security state first, then erase field, then namespace
	reg [7:0] fmt_check;
	always @* begin
		if (security_state_invalid_i)
			fmt_check = `ST_SEC_STATE;
		else if (!erase_ok)
			fmt_check = `ST_INVALID_FIELD;
		else if (ns_all && !multi_ns_supported_i)
			fmt_check = `ST_INVALID_NS;
		else
			fmt_check = `ST_OK;
	end

	// Persistent marker: only rst_n_i and a marker set touch it, so power state
	// changes elsewhere in the controller leave the count alone
	always @(posedge clk_i) begin
		if (!rst_n_i)
			preboot_load_count <= 8'h00;
		else if (marker_set)
			preboot_load_count <= cmd_dw11[`LOAD_COUNT_HI:0];
	end

	// Interrupt status and mask; status bits stay set until written with ones
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			irq_stat <= {`IRQ_W{1'b0}};
			irq_mask <= {`IRQ_W{1'b0}};
			irq <= 1'b0;
		end else begin
			irq_stat <= next_irq_stat;
			if (wr_fire && aw_addr == `REG_IRQ_MASK && w_strb[0])
				irq_mask <= w_data[`IRQ_W-1:0];
			// Built from the next status so the line lags the event by one clock only
			irq <= |(next_irq_stat & irq_mask);
		end
	end

	// AXI write side and command execution
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			aw_held <= 1'b0;
			aw_addr <= {`ADDR_W{1'b0}};
			w_held <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= `RESP_OKAY;
			cmd_ctrl <= 16'h0000;
			cmd_dw10 <= 32'h00000000;
			cmd_dw11 <= 32'h00000000;
			cmd_nsid <= 32'h00000000;
			cpl_dw0 <= 32'h00000000;
			cpl_status <= `ST_OK;
			state <= ST_IDLE;
			fmt_start <= 1'b0;
			fmt_all <= 1'b0;
			fmt_nsid <= 32'h00000000;
			fmt_settings <= 12'h000;
			ns_settings <= 12'h000;
			irq_set <= {`IRQ_W{1'b0}};
		end else begin
			irq_set <= {`IRQ_W{1'b0}};
			fmt_start <= 1'b0;
			if (s_axi_awvalid && !aw_held) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_held) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (bvalid && s_axi_bready)
				bvalid <= 1'b0;
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				bvalid <= 1'b1;
				bresp <= `RESP_OKAY;
				case (aw_addr)
					`REG_CMD_CTRL: cmd_ctrl <= ctrl_merged[`FID_HI:0];
					`REG_CMD_DW10: cmd_dw10 <= merge(cmd_dw10, w_data, w_strb);
					`REG_CMD_DW11: cmd_dw11 <= merge(cmd_dw11, w_data, w_strb);
					`REG_CMD_NSID: cmd_nsid <= merge(cmd_nsid, w_data, w_strb);
					// Interrupt registers are handled by their own block
					`REG_IRQ_STAT, `REG_IRQ_MASK: ;
					`REG_CPL_DW0, `REG_STATUS: ;
					default: bresp <= `RESP_SLVERR;
				endcase
			end
			case (state)
				ST_IDLE: begin
					if (go) begin
						cmd_ctrl <= w_data[`FID_HI:0];
						if (go_opc == `OPC_SET_FEAT && go_fid == `FID_PROGRESS) begin
							// The count itself is stored by the marker block
							cpl_dw0 <= 32'h00000000;
							cpl_status <= `ST_OK;
							irq_set[`IRQ_SET_DONE] <= 1'b1;
						end else if (go_opc == `OPC_GET_FEAT && go_fid == `FID_PROGRESS) begin
							cpl_dw0 <= {24'h000000, preboot_load_count};
							cpl_status <= `ST_OK;
							irq_set[`IRQ_GET_DONE] <= 1'b1;
						end else if (go_opc == `OPC_FORMAT) begin
							state <= ST_FMT;
						end else begin
							// A known feature command naming an unknown feature is a field error
							if (go_opc == `OPC_GET_FEAT || go_opc == `OPC_SET_FEAT)
								cpl_status <= `ST_INVALID_FIELD;
							else
								cpl_status <= `ST_INVALID_OPC;
							irq_set[`IRQ_CMD_ERR] <= 1'b1;
						end
					end
				end
				ST_FMT: begin
					cpl_dw0 <= 32'h00000000;
					if (fmt_check != `ST_OK) begin
						cpl_status <= fmt_check;
						irq_set[`IRQ_CMD_ERR] <= 1'b1;
						state <= ST_IDLE;
					end else begin
						fmt_start <= 1'b1;
						fmt_all <= ns_all;
						fmt_nsid <= cmd_nsid;
						// Reserved upper bits of the dword are never passed on
						fmt_settings <= cmd_dw10[`FMT_SET_HI:0];
						state <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					// Busy is checked only after start has had a cycle to be seen
					if (!fmt_start && !format_busy_i) begin
						ns_settings <= fmt_settings;
						cpl_status <= `ST_OK;
						irq_set[`IRQ_FMT_DONE] <= 1'b1;
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Read data decoded from the address on the bus, registered with rvalid
	reg [31:0] next_rdata;
	reg [1:0] next_rresp;
	always @* begin
		next_rdata = 32'h00000000;
		next_rresp = `RESP_OKAY;
		case (s_axi_araddr)
			`REG_CMD_CTRL: next_rdata = {16'h0000, cmd_ctrl};
			`REG_CMD_DW10: next_rdata = cmd_dw10;
			`REG_CMD_DW11: next_rdata = cmd_dw11;
			`REG_CMD_NSID: next_rdata = cmd_nsid;
			`REG_CPL_DW0: next_rdata = cpl_dw0;
			`REG_STATUS: next_rdata = status_word;
			`REG_IRQ_STAT: next_rdata = {28'h0000000, irq_stat};
			`REG_IRQ_MASK: next_rdata = {28'h0000000, irq_mask};
			default: next_rresp = `RESP_SLVERR;
		endcase
	end

	// AXI read side
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= `RESP_OKAY;
		end else begin
			arready <= 1'b0;
			if (rvalid && s_axi_rready)
				rvalid <= 1'b0;
			if (s_axi_arvalid && !arready && !rvalid) begin
				arready <= 1'b1;
				rvalid <= 1'b1;
				rdata <= next_rdata;
				rresp <= next_rresp;
			end
		end
	end

endmodule

// *** tb/progress_format_checker.sv ***
// Property checker for the command front end
`timescale 1ns/100ps
module progress_format_checker (
	input wire clk_i,
	input wire rst_n_i,
	input wire s_axi_bvalid,
	input wire security_state_invalid_i,
	input wire format_busy_i,
	input wire format_start_o,
	input wire format_all_ns_o,
	input wire [31:0] format_nsid_o,
	input wire [11:0] format_settings_o,
	input wire [2:0] secure_erase_select_o,
	input wire [11:0] ns_reported_settings_o,
	input wire [7:0] preboot_load_count_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	start_pulse_a: assert property (format_start_o |=> !format_start_o)
		else $error("format start longer than one cycle");
	erase_field_a: assert property (format_start_o |=> secure_erase_select_o == format_settings_o[11:9]
		&& secure_erase_select_o < 3'h3) else $error("erase select wrong");
	all_ns_a: assert property (format_start_o |=> format_all_ns_o == (format_nsid_o == 32'hffffffff))
		else $error("all namespace flag wrong");
	sec_block_a: assert property ($past(security_state_invalid_i) && $past(security_state_invalid_i, 2)
		|-> !format_start_o) else $error("format launched in bad security state");
	ns_report_a: assert property (!$stable(ns_reported_settings_o) |->
		ns_reported_settings_o == format_settings_o && !format_busy_i) else $error("reported settings wrong");
	settings_hold_a: assert property (format_busy_i && $past(format_busy_i) |-> $stable(format_settings_o))
		else $error("settings moved during format");
	no_restart_a: assert property (format_busy_i && $past(format_busy_i) |-> !format_start_o)
		else $error("format relaunched while busy");
	count_change_a: assert property (!$stable(preboot_load_count_o) |-> s_axi_bvalid
		|| $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("marker changed without write");
endmodule
bind progress_format_cmd progress_format_checker u_chk (.*);

// *** tb/format_engine_model.sv ***
// Format engine model answering launch pulses with a busy window
`timescale 1ns/100ps
module format_engine_model (
	input wire clk_i,
	input wire start_i,
	input wire slow_i,
	output reg busy_o
);
	reg [3:0] left = 4'h0;
	initial busy_o = 1'b0;
	// Busy rises the cycle after launch so the front end never sees an early idle
	always @(posedge clk_i) begin
		if (start_i) begin
			busy_o <= 1'b1;
			left <= slow_i ? 4'hc : 4'h1;
		end else if (left != 4'h0) begin
			left <= left - 4'h1;
		end else begin
			busy_o <= 1'b0;
		end
	end
endmodule

// *** tb/tb_top.sv ***
// Self-checking bench for the command front end
`timescale 1ns/100ps
`include "progress_format_defs.vh"
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_top;
	reg clk_i = 0, rst_n_i = 0, slow = 0, msk = 0;
	reg [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	reg [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
	reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1, s_axi_arvalid = 0, s_axi_rready = 1;
	reg [31:0] s_axi_wdata = 0, r, d, ns;
	reg [3:0] s_axi_wstrb = 0;
	reg security_state_invalid_i = 0, multi_ns_supported_i = 0;
	reg [7:0] cnt, st;
	reg [11:0] rep = 0;
	integer i, err_count = 0, n_tests = 0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_o;
	wire format_busy_i, format_start_o, format_all_ns_o;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata, format_nsid_o;
	wire [11:0] format_settings_o, ns_reported_settings_o;
	wire [2:0] secure_erase_select_o;
	wire [7:0] preboot_load_count_o;
	progress_format_cmd u_dut (.*);
	format_engine_model u_eng (.clk_i(clk_i), .start_i(format_start_o), .slow_i(slow), .busy_o(format_busy_i));
	always #5 clk_i = ~clk_i;
	task conclude;
		$display("tests %0d errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task wr(input [4:0] a, input [31:0] v);
		integer k;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		k = 0;
		do begin
			@(posedge clk_i);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			k++;
		end while (!s_axi_bvalid && k < 50);
		if (k == 50) begin err_count++; conclude; end
	endtask
	task rd(input [4:0] a);
		integer k;
		@(posedge clk_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		k = 0;
		do begin
			@(posedge clk_i);
			if (s_axi_arready) s_axi_arvalid <= 0;
			k++;
		end while (!s_axi_rvalid && k < 50);
		r = s_axi_rdata;
		if (k == 50) begin err_count++; conclude; end
	endtask
	// Issue a command, wait for its event, check and clear the status
	task cmd(input [31:0] c, input [3:0] ev);
		integer k;
		wr(`REG_CMD_CTRL, c);
		for (k = 0; k < 40 && irq_o !== 1'b1; k++) @(posedge clk_i);
		`CHK("irq line", msk, irq_o)
		rd(`REG_IRQ_STAT);
		`CHK("event", ev, r[3:0])
		wr(`REG_IRQ_STAT, 32'hf);
		rd(`REG_IRQ_STAT);
		`CHK("cleared", 4'h0, r[3:0])
	endtask
	function [7:0] nxt(input [7:0] c);
		nxt = c == 8'hff ? c : c + 8'h1;
	endfunction
	function [7:0] exp_st(input integer n);
		exp_st = n < 3 || n == 8 ? `ST_OK : n < 8 ? `ST_INVALID_FIELD : n == 9 ? `ST_INVALID_NS : `ST_SEC_STATE;
	endfunction
	initial begin
		r = $urandom(32'hb2ac);
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1;
		@(posedge clk_i);
		cnt = 0;
		for (i = 0; i < 12; i++) begin
			if (i == 1) begin wr(`REG_IRQ_MASK, 32'hf); msk = 1; end
			cnt = i == 2 ? 8'hfe : i == 8 ? 8'h00 : nxt(cnt);
			wr(`REG_CMD_DW11, {$urandom, cnt});
			cmd(32'h18009, 4'h1);
			`CHK("marker", cnt, preboot_load_count_o)
			cmd(32'h1800a, 4'h2);
			rd(`REG_CPL_DW0);
			`CHK("get", {24'h0, cnt}, r)
		end
		cmd(32'h18109, 4'h8);
		$display("marker test done");
		for (i = 0; i < 11; i++) begin
			d = $urandom;
			d[11:9] = i < 8 ? i : i % 3;
			ns = i == 8 || i == 9 ? 32'hffffffff : $urandom % 8 + 1;
			multi_ns_supported_i <= i != 9;
			security_state_invalid_i <= i == 10;
			slow <= $urandom;
			st = exp_st(i);
			wr(`REG_CMD_DW10, d);
			wr(`REG_CMD_NSID, ns);
			cmd(32'h10080, st == 0 ? 4'h4 : 4'h8);
			if (st == 0) begin
				rep = d[11:0];
				`CHK("settings", d[11:0], format_settings_o)
				`CHK("erase", d[11:9], secure_erase_select_o)
				`CHK("nsid", ns, format_nsid_o)
				`CHK("all ns", i == 8, format_all_ns_o)
				`CHK("reported", rep, ns_reported_settings_o)
			end
			rd(`REG_STATUS);
			`CHK("status", {4'h0, st} | rep, r[11:0])
		end
		$display("format test done");
		conclude;
	end
endmodule
